// File: hdl/ssl_pkg.sv
// Constants, state codes and register map of the sensor supervisor logic.
// Contract
// - Power-on flag stays low until supply passes threshold, then startup begins.
// - Supply dropping below threshold lowers flag; recovery runs a full new startup.
// - Error flag stays high from power-on until startup has finished.
// - Low reset input requests system reset; pull-up keeps open input inactive.
// - During external reset outputs are forced to mid-supply and error is high.
// - Self-test runs while its input is high; pull-down keeps it off when open.
// - Self-test superimposes a square wave of about 24 Hz on the outputs.
// - Outputs are checked continuously; error is high whenever they are invalid.
// - Acceleration overload raises the error flag too.
// - Shock restarts the readout electronics repeatedly until back in range.
// - Device is operational about 40 us after power-on reset release.
// - Supervisory sequencing is timed by the 200 kHz readout clock.
package ssl_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned SC_CLK_HZ = 200_000;
	localparam int unsigned SC_DIV = CLK_HZ / SC_CLK_HZ;
	localparam int unsigned STARTUP_US = 40;
	localparam int unsigned STARTUP_TICKS = (STARTUP_US * SC_CLK_HZ) / 1_000_000;
	localparam int unsigned ST_FREQ_HZ = 24;
	localparam int unsigned ST_HALF_TICKS = SC_CLK_HZ / (2 * ST_FREQ_HZ);

	// ----------------------------------------------------------------
	// Pin synchroniser slots and their reset levels
	// ----------------------------------------------------------------
	localparam int unsigned PIN_SUPPLY = 0;
	localparam int unsigned PIN_RSTN = 1;
	localparam int unsigned PIN_ST = 2;
	localparam int unsigned PIN_OVL = 3;
	localparam logic [3:0] PIN_RST = 4'h2;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_STATUS = 12'h004;
	localparam logic [11:0] OFS_IRQ_STAT = 12'h008;
	localparam logic [11:0] OFS_IRQ_MASK = 12'h00c;
	localparam logic [11:0] OFS_RESTARTS = 12'h010;
	localparam int unsigned CTRL_SWRST_BIT = 0;
	localparam int unsigned CTRL_ST_BIT = 1;
	localparam logic [1:0] CTRL_RST = 2'h0;
	localparam int unsigned IRQ_W = 4;
	localparam int unsigned IRQ_PWR_LOST = 0;
	localparam int unsigned IRQ_READY = 1;
	localparam int unsigned IRQ_OVERLOAD = 2;
	localparam int unsigned IRQ_EXTRST = 3;
	localparam logic [3:0] IRQ_RST = 4'h0;
	localparam logic [15:0] RESTARTS_RST = 16'h0000;

	// ----------------------------------------------------------------
	// Supervisor states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_OFF = 3'b000,
		ST_START = 3'b001,
		ST_RUN = 3'b010,
		ST_EXTRST = 3'b011,
		ST_RESTART = 3'b100
	} ssl_state_t;

endpackage

// File: hdl/ssl_st_if.sv
// Link between the supervisor and its self-test square wave generator.
`timescale 1ns/10ps
interface ssl_st_if;
	logic tick;
	logic enable;
	logic phase;
	modport ctrl (output tick, output enable, input phase);
	modport gen (input tick, input enable, output phase);
endinterface

// File: hdl/ssl_selftest.sv
// Self-test square wave generator timed by the readout clock tick.
`timescale 1ns/10ps
module ssl_selftest #(
	parameter int unsigned HALF_TICKS = ssl_pkg::ST_HALF_TICKS
) (
	input wire logic pclk,
	input wire logic presetn,
	ssl_st_if.gen st
);

	logic [15:0] cnt_q;
	logic [15:0] cnt_d;
	logic phase_q;
	logic phase_d;
	logic half_end;

	// ----------------------------------------------------------------
	// Half period counting
	// ----------------------------------------------------------------
	// The wave restarts in its low half each time self-test is enabled.
	assign half_end = st.tick && (cnt_q == 16'(HALF_TICKS - 1));
	assign cnt_d = !st.enable ? 16'h0000 : half_end ? 16'h0000 : st.tick ? cnt_q + 16'h0001 : cnt_q;
	assign phase_d = !st.enable ? 1'b0 : half_end ? !phase_q : phase_q;
	assign st.phase = phase_q;

	// Counter and phase registers.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 16'h0000;
			phase_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			phase_q <= phase_d;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	wave_toggle_a: assert property (@(posedge pclk) disable iff (!presetn)
		(st.enable && half_end) |=> (phase_q != $past(phase_q)))
		else $error("Self-test phase did not toggle at half period end.");
	wave_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
		!st.enable |=> !phase_q)
		else $error("Self-test phase high while disabled.");
	wave_run_c: cover property (@(posedge pclk) disable iff (!presetn)
		st.enable && half_end && phase_q);

endmodule

// File: hdl/ssl_top.sv
// Supervisor for power-on, external reset, self-test and overload restart.
`timescale 1ns/10ps
module ssl_top #(
	parameter int unsigned ST_HALF_TICKS = ssl_pkg::ST_HALF_TICKS
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic supply_above_threshold,
	input wire logic ext_reset_n,
	input wire logic selftest_request,
	input wire logic overload_detect,
	output logic power_on_flag,
	output logic error_flag,
	output logic outputs_force_mid,
	output logic selftest_drive,
	output logic readout_reset,
	output logic irq
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [3:0] sync1_q;
	logic [3:0] sync2_q;
	logic [7:0] div_q;
	logic [7:0] div_d;
	logic tick;
	logic supply_ok;
	logic rst_req;
	logic st_active;
	logic ovl;
	ssl_pkg::ssl_state_t state_q;
	ssl_pkg::ssl_state_t state_d;
	logic [7:0] cnt_q;
	logic [7:0] cnt_d;
	logic start_done;
	logic power_on_q;
	logic error_q;
	logic error_d;
	logic force_mid_q;
	logic st_drive_q;
	logic readout_rst_q;
	logic [1:0] ctrl_q;
	logic [3:0] irq_stat_q;
	logic [3:0] irq_mask_q;
	logic [3:0] events;
	logic [3:0] w1c;
	logic [15:0] restarts_q;
	logic [31:0] prdata_q;
	logic [31:0] rdata_mux;
	logic setup;
	logic access;
	logic wr;
	logic hit_ctrl;
	logic hit_status;
	logic hit_stat;
	logic hit_mask;
	logic hit_restarts;
	logic hit_any;
	ssl_st_if st_link();

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	// All pins are asynchronous to pclk and pass two flip-flops first.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_q <= ssl_pkg::PIN_RST;
			sync2_q <= ssl_pkg::PIN_RST;
		end else begin
			sync1_q <= {overload_detect, selftest_request, ext_reset_n, supply_above_threshold};
			sync2_q <= sync1_q;
		end
	end

	// Qualified pin levels; software bits add to the pin requests.
	assign supply_ok = sync2_q[ssl_pkg::PIN_SUPPLY];
	assign rst_req = !sync2_q[ssl_pkg::PIN_RSTN] || ctrl_q[ssl_pkg::CTRL_SWRST_BIT];
	assign st_active = supply_ok && (sync2_q[ssl_pkg::PIN_ST] || ctrl_q[ssl_pkg::CTRL_ST_BIT]);
	assign ovl = sync2_q[ssl_pkg::PIN_OVL];

	// ----------------------------------------------------------------
	// Readout clock tick
	// ----------------------------------------------------------------
	// One pclk pulse at the readout clock rate paces every sequence.
	assign tick = (div_q == 8'(ssl_pkg::SC_DIV - 1));
	assign div_d = tick ? 8'h00 : div_q + 8'h01;

	// Tick divider register.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q <= 8'h00;
		end else begin
			div_q <= div_d;
		end
	end

	// ----------------------------------------------------------------
	// Supervisor state machine
	// ----------------------------------------------------------------
	assign start_done = tick && (cnt_q == 8'(ssl_pkg::STARTUP_TICKS - 1));

	// Supply loss beats reset, which beats the normal sequence.
	always_comb begin
		state_d = state_q;
		case (state_q)
			ssl_pkg::ST_OFF: begin
				state_d = ssl_pkg::ST_START;
			end
			ssl_pkg::ST_EXTRST: begin
				state_d = ssl_pkg::ST_START;
			end
			ssl_pkg::ST_START: begin
				if (ovl) begin
					state_d = ssl_pkg::ST_RESTART;
				end else if (start_done) begin
					state_d = ssl_pkg::ST_RUN;
				end
			end
			ssl_pkg::ST_RUN: begin
				if (ovl) begin
					state_d = ssl_pkg::ST_RESTART;
				end
			end
			ssl_pkg::ST_RESTART: begin
				if (tick) begin
					state_d = ssl_pkg::ST_START;
				end
			end
			default: begin
				state_d = ssl_pkg::ST_OFF;
			end
		endcase
		if (rst_req) begin
			state_d = ssl_pkg::ST_EXTRST;
		end
		if (!supply_ok) begin
			state_d = ssl_pkg::ST_OFF;
		end
	end

	// Startup tick counter restarts on every entry to startup.
	assign cnt_d = (state_q != ssl_pkg::ST_START) ? 8'h00 : tick ? cnt_q + 8'h01 : cnt_q;

	// Outputs are valid only in the running state with nothing pending.
	assign error_d = !(state_d == ssl_pkg::ST_RUN && supply_ok && !rst_req && !ovl);

	// State and startup counter registers.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ssl_pkg::ST_OFF;
			cnt_q <= 8'h00;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
		end
	end

	// ----------------------------------------------------------------
	// Pin outputs
	// ----------------------------------------------------------------
	// Flags and analog controls all come straight from flip-flops.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			power_on_q <= 1'b0;
			error_q <= 1'b1;
			force_mid_q <= 1'b0;
			st_drive_q <= 1'b0;
			readout_rst_q <= 1'b0;
		end else begin
			power_on_q <= supply_ok;
			error_q <= error_d;
			force_mid_q <= (state_d == ssl_pkg::ST_EXTRST);
			st_drive_q <= st_active && st_link.phase;
			readout_rst_q <= (state_d == ssl_pkg::ST_RESTART);
		end
	end

	assign power_on_flag = power_on_q;
	assign error_flag = error_q;
	assign outputs_force_mid = force_mid_q;
	assign selftest_drive = st_drive_q;
	assign readout_reset = readout_rst_q;

	// ----------------------------------------------------------------
	// Self-test generator
	// ----------------------------------------------------------------
	assign st_link.tick = tick;
	assign st_link.enable = st_active;

	ssl_selftest #(
		.HALF_TICKS(ST_HALF_TICKS)
	) u_selftest (
		.pclk(pclk),
		.presetn(presetn),
		.st(st_link.gen)
	);

	// ----------------------------------------------------------------
	// Events and interrupt
	// ----------------------------------------------------------------
	assign events[ssl_pkg::IRQ_PWR_LOST] = power_on_q && !supply_ok;
	assign events[ssl_pkg::IRQ_READY] = (state_q != ssl_pkg::ST_RUN) && (state_d == ssl_pkg::ST_RUN);
	assign events[ssl_pkg::IRQ_OVERLOAD] = (state_q != ssl_pkg::ST_RESTART)
		&& (state_d == ssl_pkg::ST_RESTART);
	assign events[ssl_pkg::IRQ_EXTRST] = (state_q != ssl_pkg::ST_EXTRST)
		&& (state_d == ssl_pkg::ST_EXTRST);
	assign w1c = (wr && hit_stat) ? pwdata[3:0] : 4'h0;
	assign irq = |(irq_stat_q & irq_mask_q);

	// Sticky status: a new event wins over a clear in the same cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_q <= ssl_pkg::IRQ_RST;
		end else begin
			irq_stat_q <= (irq_stat_q & ~w1c) | events;
		end
	end

	// Count of overload restarts, wrapping.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			restarts_q <= ssl_pkg::RESTARTS_RST;
		end else if (events[ssl_pkg::IRQ_OVERLOAD]) begin
			restarts_q <= restarts_q + 16'h0001;
		end
	end

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	assign setup = psel && !penable;
	assign access = psel && penable;
	assign wr = access && pwrite;
	assign hit_ctrl = (paddr == ssl_pkg::OFS_CTRL);
	assign hit_status = (paddr == ssl_pkg::OFS_STATUS);
	assign hit_stat = (paddr == ssl_pkg::OFS_IRQ_STAT);
	assign hit_mask = (paddr == ssl_pkg::OFS_IRQ_MASK);
	assign hit_restarts = (paddr == ssl_pkg::OFS_RESTARTS);
	assign hit_any = hit_ctrl || hit_status || hit_stat || hit_mask || hit_restarts;
	assign pready = 1'b1;
	assign pslverr = access && !hit_any;
	assign prdata = prdata_q;

	// Read selection; unmapped addresses read as zero.
	always_comb begin
		if (hit_ctrl) begin
			rdata_mux = {30'h0, ctrl_q};
		end else if (hit_status) begin
			rdata_mux = {24'h0, st_drive_q, readout_rst_q, error_q, power_on_q, 1'b0, state_q};
		end else if (hit_stat) begin
			rdata_mux = {28'h0, irq_stat_q};
		end else if (hit_mask) begin
			rdata_mux = {28'h0, irq_mask_q};
		end else if (hit_restarts) begin
			rdata_mux = {16'h0, restarts_q};
		end else begin
			rdata_mux = 32'h0000_0000;
		end
	end

	// Read data is captured in the setup cycle and held through access.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
		end else if (setup) begin
			prdata_q <= rdata_mux;
		end
	end

	// Writable registers.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= ssl_pkg::CTRL_RST;
			irq_mask_q <= ssl_pkg::IRQ_RST;
		end else begin
			if (wr && hit_ctrl) begin
				ctrl_q <= pwdata[1:0];
			end
			if (wr && hit_mask) begin
				irq_mask_q <= pwdata[3:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	localparam int TICK_GAP = 200;
	logic [11:0] start_cyc_q;

	// Cycles spent in startup, for the startup time check.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			start_cyc_q <= 12'h000;
		end else if (state_q == ssl_pkg::ST_START) begin
			start_cyc_q <= start_cyc_q + 12'h001;
		end else begin
			start_cyc_q <= 12'h000;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	power_low_a: assert property (!supply_ok |=> !power_on_flag)
		else $error("Power-on flag high while supply below threshold.");
	restart_seq_a: assert property ($rose(power_on_flag) |->
		(state_q == ssl_pkg::ST_START || state_q == ssl_pkg::ST_EXTRST))
		else $error("Supply recovery did not begin a new startup.");
	err_startup_a: assert property ((state_q == ssl_pkg::ST_START) |-> error_flag)
		else $error("Error flag low during startup.");
	ext_reset_a: assert property ((rst_req && supply_ok) |=>
		(state_q == ssl_pkg::ST_EXTRST && outputs_force_mid))
		else $error("Reset request did not enter reset.");
	mid_force_a: assert property (outputs_force_mid |-> error_flag)
		else $error("Outputs forced to mid-supply without error flag.");
	st_off_a: assert property (!st_active |=> !selftest_drive)
		else $error("Self-test drive active without request.");
	err_valid_a: assert property (!error_flag |->
		(state_q == ssl_pkg::ST_RUN && power_on_flag && !outputs_force_mid))
		else $error("Error flag low while outputs invalid.");
	ovl_err_a: assert property (ovl |=> error_flag)
		else $error("Overload did not raise the error flag.");
	ovl_restart_a: assert property ((ovl && supply_ok && !rst_req
		&& (state_q == ssl_pkg::ST_START || state_q == ssl_pkg::ST_RUN))
		|=> readout_reset ##1 (readout_reset || state_q != ssl_pkg::ST_RUN))
		else $error("Overload did not restart the readout.");
	restart_len_a: assert property ($rose(readout_reset) |-> ##[1:TICK_GAP] !readout_reset)
		else $error("Readout restart pulse too long.");
	startup_time_a: assert property ((state_q == ssl_pkg::ST_START && state_d == ssl_pkg::ST_RUN)
		|-> (start_cyc_q >= 12'h577 && start_cyc_q < 12'h640))
		else $error("Startup time out of range.");
	tick_period_a: assert property (tick |-> ##200 tick)
		else $error("Readout tick period wrong.");
	err_release_a: assert property ($fell(error_flag) |->
		(!readout_reset && !outputs_force_mid && power_on_flag))
		else $error("Error released with a condition still pending.");

	run_reached_c: cover property ($rose(state_q == ssl_pkg::ST_RUN));
	overload_seen_c: cover property ($rose(readout_reset) ##[1:TICK_GAP] !readout_reset);
	selftest_wave_c: cover property ($rose(selftest_drive));
	brownout_c: cover property ($fell(power_on_flag));

endmodule

// File: verif/ssl_host_model.sv
// Behavioural host that drives the supply comparator and control pins of the supervisor.
`timescale 1ns/10ps
module ssl_host_model (
	input wire logic pclk,
	output logic supply_above_threshold,
	output logic ext_reset_n,
	output logic selftest_request,
	output logic overload_detect
);
	// Levels at time zero: supply off, reset and self-test pins left open, no shock.
	initial begin
		supply_above_threshold = 1'b0;
		ext_reset_n = 1'b1; // An open reset pin reads high through its pull-up.
		selftest_request = 1'b0; // An open self-test pin reads low through its pull-down.
		overload_detect = 1'b0;
	end

	// Each task changes its pin just after a rising edge.
	task automatic set_supply(input logic v);
		@(posedge pclk);
		supply_above_threshold <= v;
	endtask

	task automatic hold_reset(input logic v);
		@(posedge pclk);
		ext_reset_n <= ~v; // Requesting reset pulls the pin low.
	endtask

	// Self-test is only requested while no shock is applied to the sensor.
	task automatic set_selftest(input logic v);
		@(posedge pclk);
		selftest_request <= v & ~overload_detect;
	endtask

	task automatic set_overload(input logic v);
		@(posedge pclk);
		overload_detect <= v & ~selftest_request;
	endtask
endmodule

// File: verif/testbench.sv
// Self-checking bench for the supervisor: read results are matched against a queue.
`timescale 1ns/10ps
module testbench;
	localparam int unsigned HALF = 4;
	localparam int unsigned LO = 7 * ssl_pkg::SC_DIV - 10;
	localparam int unsigned HI = 8 * ssl_pkg::SC_DIV + 10;
	logic pclk;
	logic presetn;
	logic [11:0] paddr;
	logic psel;
	logic penable;
	logic pwrite;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready, pslverr, irq;
	logic supply_above_threshold, ext_reset_n, selftest_request, overload_detect;
	logic power_on_flag, error_flag, outputs_force_mid, selftest_drive, readout_reset;
	logic [5:0] pv;
	logic [32:0] exp_q[$];
	int err_count = 0;
	int compares = 0;
	int seed = 32'hcc50;
	int n, rises;
	logic prev, stayed;

	assign pv = {power_on_flag, error_flag, outputs_force_mid, readout_reset, irq, selftest_drive};

	// Clock of 25 ns period.
	always #12.5 pclk = ~pclk;

	ssl_top #(
		.ST_HALF_TICKS(HALF)
	) uut (
		.pclk(pclk),
		.presetn(presetn),
		.paddr(paddr),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.supply_above_threshold(supply_above_threshold),
		.ext_reset_n(ext_reset_n),
		.selftest_request(selftest_request),
		.overload_detect(overload_detect),
		.power_on_flag(power_on_flag),
		.error_flag(error_flag),
		.outputs_force_mid(outputs_force_mid),
		.selftest_drive(selftest_drive),
		.readout_reset(readout_reset),
		.irq(irq)
	);

	ssl_host_model host (
		.pclk(pclk),
		.supply_above_threshold(supply_above_threshold),
		.ext_reset_n(ext_reset_n),
		.selftest_request(selftest_request),
		.overload_detect(overload_detect)
	);

	// ------------------------------------------------------------
	// Comparison and bus tasks
	// ------------------------------------------------------------
	task automatic note(input string name, input logic [32:0] e, input logic [32:0] g);
		compares++;
		if (g !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", name, e, g);
		end
	endtask

	task automatic chk_bus(input logic [32:0] e, input logic [32:0] g);
		note("read data", e, g);
	endtask

	task automatic chk_pins(input logic [5:0] e);
		#1;
		note("pins", {27'h0, e}, {27'h0, pv});
	endtask

	task automatic chk_span(input string name, input logic ok);
		note(name, 33'h1, {32'h0, ok});
	endtask

	// One APB transfer; the request is held until pready is seen high at an edge.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, input logic er, input logic [31:0] e);
		exp_q.push_back({er, e});
		apb(1'b0, a, 32'h00000000);
	endtask

	// Waits a bounded time for one pin to reach a level, counting the cycles.
	task automatic wait_pin(input int k, input logic v, output int c);
		c = 0;
		while (pv[k] !== v && c < 4000) begin
			@(posedge pclk);
			#1;
			c++;
		end
	endtask

	task automatic end_of_test();
		if (exp_q.size() != 0) begin
			note("pending reads", 33'h0, 33'(exp_q.size()));
		end
		$display("Comparisons %0d, mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Takes the oldest expectation whenever a read access completes.
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			if (exp_q.size() == 0) begin
				note("read without expectation", 33'h0, 33'h1);
			end else begin
				chk_bus(exp_q.pop_front(), {pslverr, prdata});
			end
		end
	end

	// Watchdog that ends a hung run.
	initial begin
		repeat (60000) @(posedge pclk);
		err_count++;
		end_of_test();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		paddr = 12'h000;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		pwdata = $random(seed);
		@(posedge pclk);
		chk_pins(6'b010000);
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (100) @(posedge pclk);
		chk_pins(6'b010000);
		rd(ssl_pkg::OFS_STATUS, 1'b0, 32'h00000020);
		rd(ssl_pkg::OFS_CTRL, 1'b0, 32'h00000000);
		rd(ssl_pkg::OFS_IRQ_MASK, 1'b0, 32'h00000000);
		rd(12'h014, 1'b1, 32'h00000000);
		apb(1'b1, 12'h014, $random(seed));
		apb(1'b1, ssl_pkg::OFS_RESTARTS, $random(seed));
		rd(ssl_pkg::OFS_RESTARTS, 1'b0, 32'h00000000);
		// Power-up runs a startup of about 40 us on the readout clock.
		host.set_supply(1'b1);
		wait_pin(5, 1'b1, n);
		chk_pins(6'b110000);
		wait_pin(4, 1'b0, n);
		chk_span("startup time", n >= LO && n <= HI);
		rd(ssl_pkg::OFS_STATUS, 1'b0, 32'h00000012);
		apb(1'b1, ssl_pkg::OFS_IRQ_STAT, 32'h0000000f);
		rd(ssl_pkg::OFS_IRQ_STAT, 1'b0, 32'h00000000);
		// External reset forces mid-supply outputs; a masked event keeps irq low.
		host.hold_reset(1'b1);
		repeat (5) @(posedge pclk);
		chk_pins(6'b111000);
		host.hold_reset(1'b0);
		wait_pin(4, 1'b0, n);
		chk_pins(6'b100000);
		rd(ssl_pkg::OFS_IRQ_STAT, 1'b0, 32'h0000000a);
		apb(1'b1, ssl_pkg::OFS_IRQ_MASK, 32'h00000008);
		chk_pins(6'b100010);
		apb(1'b1, ssl_pkg::OFS_IRQ_STAT, 32'h00000008);
		chk_pins(6'b100000);
		rd(ssl_pkg::OFS_IRQ_STAT, 1'b0, 32'h00000002);
		// A single-cycle shock restarts the readout once.
		host.set_overload(1'b1);
		host.set_overload(1'b0);
		wait_pin(2, 1'b1, n);
		chk_pins(6'b110100);
		wait_pin(4, 1'b0, n);
		rd(ssl_pkg::OFS_RESTARTS, 1'b0, 32'h00000001);
		rd(ssl_pkg::OFS_IRQ_STAT, 1'b0, 32'h00000006);
		// A long shock repeats the restart with the error flag held high.
		host.set_overload(1'b1);
		rises = 0;
		prev = 1'b0;
		stayed = 1'b1;
		n = 0;
		repeat (2500) begin
			@(posedge pclk);
			#1;
			if (pv[2] === 1'b1 && prev !== 1'b1) rises++;
			prev = pv[2];
			if (n > 3 && pv[4] !== 1'b1) stayed = 1'b0;
			n++;
		end
		chk_span("restart repeated", rises >= 2);
		chk_span("error during shock", stayed);
		host.set_overload(1'b0);
		wait_pin(4, 1'b0, n);
		chk_pins(6'b100000);
		apb(1'b1, ssl_pkg::OFS_IRQ_STAT, 32'h0000000f);
		// Brownout drops the flag and runs a full new startup.
		host.set_supply(1'b0);
		wait_pin(5, 1'b0, n);
		chk_pins(6'b010000);
		host.set_supply(1'b1);
		wait_pin(5, 1'b1, n);
		wait_pin(4, 1'b0, n);
		chk_span("startup after brownout", n >= LO && n <= HI);
		rd(ssl_pkg::OFS_IRQ_STAT, 1'b0, 32'h00000003);
		// The software reset bit acts as the reset pin; its event shows on irq.
		apb(1'b1, ssl_pkg::OFS_CTRL, 32'h00000001);
		repeat (3) @(posedge pclk);
		chk_pins(6'b111010);
		rd(ssl_pkg::OFS_CTRL, 1'b0, 32'h00000001);
		apb(1'b1, ssl_pkg::OFS_CTRL, 32'h00000000);
		wait_pin(4, 1'b0, n);
		chk_pins(6'b100010);
		apb(1'b1, ssl_pkg::OFS_IRQ_STAT, 32'h0000000f);
		// Self-test square wave half period is counted in readout ticks.
		host.set_selftest(1'b1);
		wait_pin(0, 1'b1, n);
		wait_pin(0, 1'b0, n);
		chk_span("selftest half period", n == ssl_pkg::SC_DIV * HALF);
		host.set_selftest(1'b0);
		repeat (1000) @(posedge pclk);
		chk_pins(6'b100000);
		// The software self-test bit runs the same wave as the pin.
		apb(1'b1, ssl_pkg::OFS_CTRL, 32'h00000002);
		wait_pin(0, 1'b1, n);
		wait_pin(0, 1'b0, n);
		chk_span("software selftest half period", n == ssl_pkg::SC_DIV * HALF);
		apb(1'b1, ssl_pkg::OFS_CTRL, 32'h00000000);
		repeat (10) @(posedge pclk);
		chk_pins(6'b100000);
		end_of_test();
	end
endmodule
